// file: dsb_map.svh
// Register map, field positions and timing counts for the sync FIFO and signature block
`ifndef DSB_MAP_SVH
`define DSB_MAP_SVH
// Register offsets
`define DSB_REG_MODE      5'h00
`define DSB_REG_IRQ       5'h01
`define DSB_REG_FIFO      5'h07
`define DSB_REG_WATCH     5'h08
`define DSB_REG_TEST      5'h11
`define DSB_REG_SIG0      5'h12
`define DSB_REG_SIG1      5'h13
`define DSB_REG_SIG2      5'h14
`define DSB_REG_SIG3      5'h15
// Field positions
`define DSB_MODE_FIFO_EN  2
`define DSB_IRQ_SYNC_EN   2
`define DSB_IRQ_SYNC_FLG  6
`define DSB_WATCH_EN      7
`define DSB_WATCH_AUTO    6
`define DSB_WATCH_THR     0
`define DSB_TEST_CLR      0
`define DSB_TEST_FIFO_EN  1
`define DSB_TEST_RX_EN    2
`define DSB_TEST_READ     5
// Serial port: read flag in the instruction byte, bits per frame
`define DSB_SPI_RD_BIT    7
`define DSB_SPI_LAST_INST 4'h7
`define DSB_SPI_LAST_BIT  4'hf
// Filter: largest shift, two whole status steps
`define DSB_SYNC_FILTER_LENGTH_MAX      4'hc
`define DSB_FILT_TWO      15'h2000
// Extra converter-clock stages on the FIFO path beyond bypass
`define DSB_FIFO_EXTRA    4
`endif

// file: dsb_pkg.sv
// Types and helpers shared by the sync FIFO and signature block
package dsb_pkg;
  typedef logic [13:0] dsb_word_t;
  typedef logic [27:0] dsb_pair_t;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_INST = 3'b010,
    SP_DATA = 3'b100
  } dsb_spi_e;
  function automatic logic [2:0] dsb_gray2bin(input logic [2:0] g);
    return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction : dsb_gray2bin
endpackage : dsb_pkg

// file: dsb_sig_lfsr.sv
// One 32-bit signature compactor for one sample phase
`timescale 1ns/1ps
module dsb_sig_lfsr import dsb_pkg::*; (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        clr_i,
  input  wire logic        en_i,
  // Sample and signature
  input  wire dsb_word_t   d_i,
  output logic [31:0]      sig_o
);
  logic [31:0] sig_nxt;
  // Feedback into the low bits, plain shift above
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_bit
      if (b == 0) begin : g_fb
        assign sig_nxt[b] = ~(sig_o[31] ^ d_i[0]);
      end else if (b < 14) begin : g_mix
        assign sig_nxt[b] = ~(sig_o[b-1] ^ d_i[b]);
      end else begin : g_shift
        assign sig_nxt[b] = sig_o[b-1];
      end
    end
  endgenerate
  // Signature register: clear holds zero, zero words leave it alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sig_o <= 32'h0000_0000;
    end else if (clr_i) begin
      sig_o <= 32'h0000_0000;
    end else if (en_i && (d_i != 14'h0000)) begin
      sig_o <= sig_nxt;
    end
  end
endmodule : dsb_sig_lfsr

// file: dsb_fifo_mem.sv
// Eight-word sample-pair memory, written on the link clock, read registered
`timescale 1ns/1ps
module dsb_fifo_mem import dsb_pkg::*; (
  // Write side, link clock
  input  wire logic        wr_clk_i,
  input  wire logic        wr_rst_i,
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  wr_addr_i,
  input  wire dsb_pair_t   wr_data_i,
  // Read side, converter clock
  input  wire logic        rd_clk_i,
  input  wire logic        rd_rst_i,
  input  wire logic [2:0]  rd_addr_i,
  output dsb_pair_t        rd_data_o
);
  dsb_pair_t mem [8];
  // Write port, cleared by reset so unwritten words read as zero
  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      for (int i = 0; i < 8; i++) mem[i] <= 28'h000_0000;
    end else if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
  // Registered read port
  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      rd_data_o <= 28'h000_0000;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule : dsb_fifo_mem

// file: dsb_top.sv
// Sync FIFO controller with phase watch, bypass and signature self-test
`timescale 1ns/1ps
`include "dsb_map.svh"
module dsb_top import dsb_pkg::*; (
  // Converter clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Source link
  input  wire logic        source_data_clock_i,
  input  wire dsb_word_t   data_i,
  // Serial register port
  input  wire logic        spi_clk_i,
  input  wire logic        spi_csn_i,
  input  wire logic        spi_dat_i,
  output logic             spi_dat_o,
  output logic             spi_dat_oe_o,
  // Converter samples and interrupt
  output dsb_word_t        dac_ph1_o,
  output dsb_word_t        dac_ph2_o,
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic fifo_en_r, irq_en_r, flag_r, watch_r, auto_r, thr_r;
  logic [3:0] sync_filter_length_r, shamt;
  logic [1:0] offset_r, sel_r;
  logic clr_r, fsig_en_r, rsig_en_r, rd_en_r;
  logic [2:0] cs1_r, cs2_r;
  logic sclk3_r, rise, fall;
  dsb_spi_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, inst_r, rd_byte;
  logic wr_stb_r;
  logic [2:0] lk1_r, lk2_r;
  dsb_word_t rise_r, fall_r;
  dsb_pair_t rx_r, byp1_r, byp2_r, mem_q, pipe_r [`DSB_FIFO_EXTRA+1];
  logic [2:0] wr_cnt_r, wr_gray_r, wg1_r, wg2_r, rd_cnt_r, rd_addr, status_r;
  logic upd_r, chk_r, vld_r, viol, fix;
  logic [14:0] filt_r;
  logic signed [15:0] diff, step;
  logic [31:0] rsig [2], fsig [2], rsig1_r [2], rsig2_r [2], sel_sig;
  ////////////////////////////////////////////////////////////////////////////
  // Serial port pin synchronisers and clock edges
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs1_r   <= 3'h1;
      cs2_r   <= 3'h1;
      sclk3_r <= 1'b0;
    end else begin
      cs1_r   <= {spi_clk_i, spi_dat_i, spi_csn_i};
      cs2_r   <= cs1_r;
      sclk3_r <= cs2_r[2];
    end
  end
  assign rise = cs2_r[2] & ~sclk3_r;
  assign fall = ~cs2_r[2] & sclk3_r;
  // Frame: instruction byte, then one data byte, MSB first
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= SP_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      inst_r <= 8'h00;
      wr_stb_r <= 1'b0;
      spi_dat_o <= 1'b0;
      spi_dat_oe_o <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (cs2_r[0]) begin
        st_r <= SP_IDLE;
        cnt_r <= 4'h0;
        spi_dat_oe_o <= 1'b0;
      end else begin
        case (st_r)
          SP_IDLE: st_r <= SP_INST;
          SP_INST: if (rise) begin
            sh_r <= {sh_r[6:0], cs2_r[1]};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == `DSB_SPI_LAST_INST) begin
              inst_r <= {sh_r[6:0], cs2_r[1]};
              st_r <= SP_DATA;
            end
          end
          SP_DATA: begin
            if (rise) begin
              sh_r <= {sh_r[6:0], cs2_r[1]};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == `DSB_SPI_LAST_BIT) begin
                st_r <= SP_IDLE;
                cnt_r <= 4'h0;
                wr_stb_r <= ~inst_r[`DSB_SPI_RD_BIT];
              end
            end
            if (fall && inst_r[`DSB_SPI_RD_BIT]) begin
              spi_dat_oe_o <= 1'b1;
              spi_dat_o <= rd_byte[~cnt_r[2:0]];
            end
          end
          default: st_r <= SP_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb begin
    rd_byte = 8'h00;
    case (inst_r[4:0])
      `DSB_REG_MODE:  rd_byte[`DSB_MODE_FIFO_EN] = fifo_en_r;
      `DSB_REG_IRQ:   rd_byte = {1'b0, flag_r, 3'h0, irq_en_r, 2'h0};
      `DSB_REG_FIFO:  rd_byte = {1'b0, status_r, 2'h0, offset_r};
      `DSB_REG_WATCH: rd_byte = {watch_r, auto_r, sync_filter_length_r, 1'b0, thr_r};
      `DSB_REG_TEST:  rd_byte = {sel_r, rd_en_r, 2'h0, rsig_en_r, fsig_en_r, clr_r};
      `DSB_REG_SIG0:  rd_byte = rd_en_r ? sel_sig[7:0] : 8'h00;
      `DSB_REG_SIG1:  rd_byte = rd_en_r ? sel_sig[15:8] : 8'h00;
      `DSB_REG_SIG2:  rd_byte = rd_en_r ? sel_sig[23:16] : 8'h00;
      `DSB_REG_SIG3:  rd_byte = rd_en_r ? sel_sig[31:24] : 8'h00;
      default:        rd_byte = 8'h00;
    endcase
  end
  // Mode, interrupt enable, watch and test control writes
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_en_r <= 1'b0;
      irq_en_r <= 1'b0;
      {watch_r, auto_r, sync_filter_length_r, thr_r} <= 7'h00;
      {sel_r, rd_en_r, rsig_en_r, fsig_en_r, clr_r} <= 6'h00;
    end else if (wr_stb_r) begin
      if (inst_r[4:0] == `DSB_REG_MODE) fifo_en_r <= sh_r[`DSB_MODE_FIFO_EN];
      if (inst_r[4:0] == `DSB_REG_IRQ) irq_en_r <= sh_r[`DSB_IRQ_SYNC_EN];
      if (inst_r[4:0] == `DSB_REG_WATCH) {watch_r, auto_r, sync_filter_length_r, thr_r} <=
          {sh_r[7:2], sh_r[0]};
      if (inst_r[4:0] == `DSB_REG_TEST) {sel_r, rd_en_r, rsig_en_r, fsig_en_r, clr_r} <=
          {sh_r[7:5], sh_r[2:0]};
    end
  end
  // Sticky sync flag, set beats write-one-to-clear
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_r <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (watch_r && vld_r && viol) begin
        flag_r <= 1'b1;
      end else if (wr_stb_r && inst_r[4:0] == `DSB_REG_IRQ && sh_r[`DSB_IRQ_SYNC_FLG]) begin
        flag_r <= 1'b0;
      end
      irq_o <= flag_r & irq_en_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Link domain: controls in, DDR capture, write pointer
  always_ff @(posedge source_data_clock_i or posedge reset_i) begin
    if (reset_i) begin
      lk1_r <= 3'h0;
      lk2_r <= 3'h0;
    end else begin
      lk1_r <= {fifo_en_r, clr_r, rsig_en_r};
      lk2_r <= lk1_r;
    end
  end
  always_ff @(negedge source_data_clock_i or posedge reset_i) begin
    if (reset_i) fall_r <= 14'h0000;
    else fall_r <= data_i;
  end
  always_ff @(posedge source_data_clock_i or posedge reset_i) begin
    if (reset_i) begin
      rise_r <= 14'h0000;
      rx_r <= 28'h000_0000;
      wr_cnt_r <= 3'h0;
      wr_gray_r <= 3'h0;
    end else begin
      rise_r <= data_i;
      rx_r <= {fall_r, rise_r};
      if (lk2_r[2]) begin
        wr_cnt_r <= wr_cnt_r + 3'h1;
        wr_gray_r <= (wr_cnt_r + 3'h1) ^ ((wr_cnt_r + 3'h1) >> 1);
      end
    end
  end
  dsb_fifo_mem u_mem (
    .wr_clk_i  (source_data_clock_i),
    .wr_rst_i  (reset_i),
    .wr_en_i   (lk2_r[2]),
    .wr_addr_i (wr_cnt_r),
    .wr_data_i (rx_r),
    .rd_clk_i  (ref_clk_i),
    .rd_rst_i  (reset_i),
    .rd_addr_i (rd_addr),
    .rd_data_o (mem_q)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Converter domain: pointers, phase status and filter
  // Offset moves read pointer by two
  assign rd_addr = rd_cnt_r + {offset_r, 1'b0};
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wg1_r <= 3'h0;
      wg2_r <= 3'h0;
      rd_cnt_r <= 3'h0;
      status_r <= 3'h0;
      upd_r <= 1'b0;
      chk_r <= 1'b0;
    end else begin
      wg1_r <= wr_gray_r;
      wg2_r <= wg1_r;
      rd_cnt_r <= fifo_en_r ? rd_cnt_r + 3'h1 : 3'h0;
      upd_r <= fifo_en_r && (rd_cnt_r == 3'h0);
      chk_r <= upd_r;
      if (fifo_en_r && rd_cnt_r == 3'h0) status_r <= dsb_gray2bin(wg2_r) - rd_addr;
    end
  end
  assign shamt = (sync_filter_length_r > `DSB_SYNC_FILTER_LENGTH_MAX) ? `DSB_SYNC_FILTER_LENGTH_MAX : sync_filter_length_r;
  always_comb begin
    diff = signed'({1'b0, status_r, 12'h000}) - signed'({1'b0, filt_r});
    step = diff >>> shamt;
    if (diff > 16'sh0000 && step == 16'sh0000) step = 16'sh0001;
  end
  assign viol = thr_r ? (filt_r[14:13] == 2'b00 || filt_r[14:13] == 2'b11)
                      : (filt_r[14:12] == 3'h0 || filt_r[14:12] == 3'h7);
  assign fix = chk_r && watch_r && auto_r && vld_r && viol;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      filt_r <= 15'h0000;
      vld_r <= 1'b0;
    end else if (!fifo_en_r) begin
      vld_r <= 1'b0;
    end else if (upd_r) begin
      filt_r <= vld_r ? filt_r + step[14:0] : {status_r, 12'h000};
      vld_r <= 1'b1;
    end else if (fix) begin
      filt_r <= filt_r[14] ? filt_r - `DSB_FILT_TWO : filt_r + `DSB_FILT_TWO;
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      offset_r <= 2'h0;
    end else if (wr_stb_r && inst_r[4:0] == `DSB_REG_FIFO) begin
      offset_r <= sh_r[1:0];
    end else if (fix) begin
      offset_r <= filt_r[14] ? offset_r + 2'h1 : offset_r - 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output path: bypass or FIFO with pipeline
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byp1_r <= 28'h000_0000;
      byp2_r <= 28'h000_0000;
      for (int i = 0; i <= `DSB_FIFO_EXTRA; i++) pipe_r[i] <= 28'h000_0000;
      dac_ph1_o <= 14'h0000;
      dac_ph2_o <= 14'h0000;
    end else begin
      byp1_r <= rx_r;
      byp2_r <= byp1_r;
      pipe_r[0] <= mem_q;
      for (int i = 1; i <= `DSB_FIFO_EXTRA; i++) pipe_r[i] <= pipe_r[i-1];
      {dac_ph2_o, dac_ph1_o} <= fifo_en_r ? pipe_r[`DSB_FIFO_EXTRA] : byp2_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Signatures
  // Receiver stage and FIFO stage
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_ph
      dsb_sig_lfsr u_rx (
        .clk_i (source_data_clock_i),
        .rst_i (reset_i),
        .clr_i (lk2_r[1]),
        .en_i  (lk2_r[0]),
        .d_i   (rx_r[14*p +: 14]),
        .sig_o (rsig[p])
      );
      dsb_sig_lfsr u_ff (
        .clk_i (ref_clk_i),
        .rst_i (reset_i),
        .clr_i (clr_r),
        .en_i  (fsig_en_r),
        .d_i   (p == 0 ? dac_ph1_o : dac_ph2_o),
        .sig_o (fsig[p])
      );
    end
  endgenerate
  // Receiver signatures into converter domain, read when quiet
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsig1_r <= '{2{32'h0000_0000}};
      rsig2_r <= '{2{32'h0000_0000}};
    end else begin
      rsig1_r <= rsig;
      rsig2_r <= rsig1_r;
    end
  end
  assign sel_sig = sel_r[1] ? fsig[sel_r[0]] : rsig2_r[sel_r[0]];
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_fifo_steady;
    fifo_en_r [*8];
  endsequence
  sequence s_clr_held;
    clr_r [*2];
  endsequence
  a_irq_pin_drive: assert property (flag_r && irq_en_r |=> irq_o)
    else $error("irq pin not raised");
  a_watch_flag_set: assert property (watch_r && vld_r && viol |=> flag_r)
    else $error("sync flag missed");
  a_watch_wide_thr: assert property (watch_r && vld_r && thr_r && filt_r[14:12] == 3'h6
    |=> flag_r)
    else $error("wide threshold missed");
  a_auto_offset_step: assert property (fix && !wr_stb_r |=> offset_r != $past(offset_r))
    else $error("auto offset not updated");
  a_filter_zero_len: assert property (upd_r && vld_r && shamt == 4'h0
    |=> filt_r == {$past(status_r), 12'h000})
    else $error("unfiltered status wrong");
  a_filter_len_cap: assert property (upd_r && vld_r && sync_filter_length_r > 4'hc && filt_r[11:0] == 12'h000
    && status_r != filt_r[14:12] |=>
    filt_r[11:0] == 12'($past(status_r)) - 12'($past(filt_r[14:12])))
    else $error("filter length not capped");
  a_bypass_path: assert property (!fifo_en_r [*2] |-> {dac_ph2_o, dac_ph1_o} == $past(byp2_r))
    else $error("bypass data wrong");
  a_fifo_latency: assert property (s_fifo_steady |-> {dac_ph2_o, dac_ph1_o} == $past(mem_q, 6))
    else $error("fifo latency wrong");
  a_offset_jump: assert property (fifo_en_r && $past(fifo_en_r) &&
    offset_r == $past(offset_r) + 2'h1 |-> rd_addr == $past(rd_addr) + 3'h3)
    else $error("read pointer jump wrong");
  a_sig_clear: assert property (s_clr_held |-> fsig[0] == 32'h0 && fsig[1] == 32'h0)
    else $error("signature not cleared");
  a_sig_byte_top: assert property (inst_r[4:0] == `DSB_REG_SIG3 && rd_en_r && sel_r == 2'h2
    |-> rd_byte == fsig[0][31:24])
    else $error("signature byte order wrong");
endmodule : dsb_top

// file: dsb_src_model.sv
// Source data model: DDR word pairs on a link clock gated to frames
`timescale 1ns/1ps
module dsb_src_model import dsb_pkg::*; (
  // Link outputs
  output logic      clk_o,
  output dsb_word_t data_o
);
  ////////////////////////////////////////////////////////////////
  // Clock parked low between frames
  initial begin
    clk_o  = 1'b0;
    data_o = 14'h0000;
  end

  // One link period: first word on rise, second on fall, second word held after
  task automatic pair(input dsb_word_t a, input dsb_word_t b);
    data_o = a;
    #16 clk_o = 1'b1;
    #16 data_o = b;
    #16 clk_o = 1'b0;
    #16;
  endtask : pair

  task automatic idle(input int n);
    repeat (n) pair(14'h0000, 14'h0000);
  endtask : idle
endmodule : dsb_src_model

// file: testbench.sv
// Self-checking bench for the sync FIFO and signature block
`timescale 1ns/1ps
`include "dsb_map.svh"
module testbench import dsb_pkg::*;;
  ////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        ref_clk;
  logic        reset;
  logic        spi_clk;
  logic        spi_csn;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_oe;
  logic        src_clk;
  dsb_word_t   src_data;
  dsb_word_t   ph1;
  dsb_word_t   ph2;
  logic        irq;
  int          miscompares;
  int          total_checks;
  logic [31:0] seed;

  // Source model and design
  dsb_src_model u_src (.clk_o(src_clk), .data_o(src_data));
  dsb_top u_dut (
    .ref_clk_i(ref_clk), .reset_i(reset),
    .source_data_clock_i(src_clk), .data_i(src_data),
    .spi_clk_i(spi_clk), .spi_csn_i(spi_csn), .spi_dat_i(spi_mosi),
    .spi_dat_o(spi_miso), .spi_dat_oe_o(spi_oe),
    .dac_ph1_o(ph1), .dac_ph2_o(ph2), .irq_o(irq)
  );

  // Converter clock, 40 ns
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////
  // Random source and expected signature step
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [31:0] sig_step(input logic [31:0] s, input dsb_word_t w);
    logic [31:0] n;
    n = {s[30:0], 1'b0};
    n[13:0] = ~({s[12:0], s[31]} ^ w);
    return (w == 14'h0000) ? s : n;
  endfunction : sig_step

  // Compare and count
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One serial frame, half period four converter clocks
  task automatic spi(input logic [7:0] inst, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {inst, wd};
    rdat = 8'h00;
    @(negedge ref_clk) spi_csn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_clk = 1'b0;
      spi_mosi = sh[15-i];
      repeat (4) @(negedge ref_clk);
      if (i >= 8) rdat = {rdat[6:0], spi_miso};
      if (i == 15 && inst[7]) check("read drive enable", 32'(spi_oe), 32'h1);
      spi_clk = 1'b1;
      repeat (4) @(negedge ref_clk);
    end
    spi_clk = 1'b0;
    repeat (2) @(negedge ref_clk);
    spi_csn = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : spi

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi({3'b000, a}, d, x);
  endtask : wr

  task automatic rdr(input logic [4:0] a, output logic [7:0] d);
    spi({3'b100, a}, 8'h00, d);
  endtask : rdr

  // select, read enable, both stage enables, then four bytes
  task automatic rsig(input logic [1:0] sel, output logic [31:0] s);
    logic [7:0] x;
    wr(`DSB_REG_TEST, {sel, 6'h26});
    for (int b = 0; b < 4; b++) begin
      rdr(`DSB_REG_SIG0 + 5'(b), x);
      s[8*b +: 8] = x;
    end
  endtask : rsig

  // One self-test run; keep selects whether results are judged
  task automatic bist_run(input logic keep);
    logic [31:0] e1;
    logic [31:0] e2;
    logic [31:0] s;
    dsb_word_t   a;
    dsb_word_t   b;
    e1 = 32'h0;
    e2 = 32'h0;
    wr(`DSB_REG_TEST, 8'h07);
    u_src.idle(50);
    wr(`DSB_REG_TEST, 8'h06);
    u_src.idle(8);
    for (int k = 0; k < 4; k++) begin
      rsig(2'(k), s);
      if (keep) check("cleared signature", s, 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      a = (i == 5) ? 14'h0000 : seed[13:0];
      b = (i == 9) ? 14'h3fff : seed[27:14];
      e1 = sig_step(e1, a);
      e2 = sig_step(e2, b);
      u_src.pair(a, b);
    end
    u_src.idle(8);
    rsig(2'b00, s);
    if (keep) check("rx phase 1 signature", s, e1);
    rsig(2'b01, s);
    if (keep) check("rx phase 2 signature", s, e2);
  endtask : bist_run

  // Closing verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // Watchdog well past the expected run length
  initial begin
    #2000000;
    miscompares++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] x;
    logic [2:0] st0;
    logic [2:0] st;
    logic       hit;
    logic [1:0] kv;
    dsb_word_t  w1;
    dsb_word_t  w2;
    reset = 1'b1;
    spi_clk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
    miscompares = 0;
    total_checks = 0;
    seed = 32'h5d7b905e;
    kv = 2'h0;
    // reset held twice with the link running
    fork
      repeat (20) @(negedge ref_clk);
      u_src.idle(16);
    join
    @(negedge ref_clk) reset = 1'b0;
    u_src.idle(16);
    @(negedge ref_clk) reset = 1'b1;
    u_src.idle(16);
    @(negedge ref_clk) reset = 1'b0;
    $display("test reset done");
    // flush run discarded, second run judged
    bist_run(1'b0);
    bist_run(1'b1);
    wr(`DSB_REG_TEST, 8'h06);
    rdr(`DSB_REG_SIG3, x);
    check("signature without read enable", 32'(x), 32'h0);
    $display("test signature done");
    // Register readback and unmapped address
    seed = lfsr_next(seed);
    wr(`DSB_REG_WATCH, seed[7:0] & 8'h3d);
    rdr(`DSB_REG_WATCH, x);
    check("watch control", 32'(x & 8'h3d), 32'(seed[7:0] & 8'h3d));
    wr(5'h1f, 8'ha5);
    rdr(5'h1f, x);
    check("unmapped register", 32'(x), 32'h0);
    // Bypass then FIFO path with a held pair
    seed = lfsr_next(seed);
    w1 = seed[13:0];
    w2 = seed[29:16];
    // Path chosen first so the pairs also fill the FIFO
    for (int f = 0; f < 2; f++) begin
      wr(`DSB_REG_MODE, 8'(4 * f));
      repeat (12) u_src.pair(w1, w2);
      repeat (40) @(negedge ref_clk);
      check("phase 1 output", 32'(ph1), 32'(w1));
      check("phase 2 output", 32'(ph2), 32'(w2));
    end
    $display("test data path done");
    // FIFO enabled, link parked so the pointer phase holds still
    wr(`DSB_REG_FIFO, 8'h00);
    wr(`DSB_REG_WATCH, 8'h00);
    repeat (40) @(negedge ref_clk);
    rdr(`DSB_REG_FIFO, x);
    st0 = x[6:4];
    for (int t = 0; t < 2; t++) begin
      for (int k = 0; k < 4; k++) begin
        st = st0 - 3'(2 * k);
        hit = (st == 3'h0) || (st == 3'h7) || (t == 1 && (st == 3'h1 || st == 3'h6));
        if (hit && t == 0) kv = 2'(k);
        wr(`DSB_REG_FIFO, 8'(k));
        wr(`DSB_REG_WATCH, {7'h40, 1'(t)});
        wr(`DSB_REG_IRQ, 8'h44);
        repeat (40) @(negedge ref_clk);
        rdr(`DSB_REG_FIFO, x);
        check("pointer phase status", 32'(x[6:4]), 32'(st));
        check("read phase offset", 32'(x[1:0]), 32'(k));
        rdr(`DSB_REG_IRQ, x);
        check("sync flag", 32'(x[6]), 32'(hit));
        check("interrupt pin", 32'(irq), 32'(hit));
      end
    end
    // auto mode started from a violating offset
    wr(`DSB_REG_FIFO, 8'(kv));
    wr(`DSB_REG_WATCH, 8'hc0);
    wr(`DSB_REG_IRQ, 8'h40);
    repeat (100) @(negedge ref_clk);
    rdr(`DSB_REG_FIFO, x);
    check("auto status", 32'(x[6:4] != 3'h0 && x[6:4] != 3'h7), 32'h1);
    check("auto offset", 32'(x[1:0] != kv), 32'h1);
    $display("test phase watch done");
    end_of_test();
  end
endmodule : testbench
